/* inc/pals_pkg.sv */
/*
  Shared constants for the proximity / ambient light measurement sequencer:
  APB register offsets, field positions, reset values, command codes,
  sequencer states and timing counts. Assumes a 25 MHz pclk.
*/
package pals_pkg;
  localparam int CLK_PERIOD_NS  = 40;
  localparam int INTEG_BASE_NS  = 25600;  // 25.6 us shortest integration
  localparam int INTEG_BASE_CYC = (INTEG_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INTEG_GAIN_MAX = 7;      // base << 7 gives 3.28 ms
  localparam int RATE_UNIT_NS   = 32000;  // unit of autonomous rate counts
  localparam int RATE_UNIT_CYC  = RATE_UNIT_NS / CLK_PERIOD_NS;

  localparam int NUM_PS = 3;
  localparam int NUM_CH = 5;              // ps0..ps2, visible, infrared
  localparam int CH_VIS = 3;
  localparam int CH_IR  = 4;

  localparam logic [7:0] OFF_CMD     = 8'h00;
  localparam logic [7:0] OFF_RESP    = 8'h04;
  localparam logic [7:0] OFF_CHANNEL_SELECT_LIST  = 8'h08;
  localparam logic [7:0] OFF_PS_LED  = 8'h0C;
  localparam logic [7:0] OFF_LED_CUR = 8'h10;
  localparam logic [7:0] OFF_ADC_CFG = 8'h14;
  localparam logic [7:0] OFF_RATE    = 8'h18;
  localparam logic [7:0] OFF_INT_CFG = 8'h1C;
  localparam logic [7:0] OFF_INT_ST  = 8'h20;
  localparam logic [7:0] OFF_PS_THR0 = 8'h24;
  localparam logic [7:0] OFF_WIN     = 8'h30;
  localparam logic [7:0] OFF_DATA0   = 8'h34;

  localparam int FLD_W        = 4;        // nibble per LED / ADC group
  localparam int ADC_RANGE    = 3;        // range bit inside an ADC group
  localparam int IC_PS_SET    = 0;
  localparam int IC_PS_THR    = 1;
  localparam int IC_ALS_EVERY = 4;
  localparam int IC_ALS_WIN   = 5;
  localparam int IC_WIN_IR    = 6;
  localparam int ST_PS_SET    = 0;
  localparam int ST_PS_THR    = 1;
  localparam int ST_ALS_SMP   = 4;
  localparam int ST_ALS_WIN   = 5;
  localparam int RESP_BUSY    = 8;

  localparam logic [4:0]  CHANNEL_SELECT_LIST_RST  = 5'h09;
  localparam logic [11:0] PS_LED_RST  = 12'h421;
  localparam logic [11:0] LED_CUR_RST = 12'h000;
  localparam logic [11:0] ADC_CFG_RST = 12'h000;
  localparam logic [15:0] PS_SAT      = 16'h0FFF;
  localparam logic [15:0] ALS_SAT     = 16'hFFFF;

  localparam logic [1:0] ZONE_BELOW  = 2'h0;
  localparam logic [1:0] ZONE_INSIDE = 2'h1;
  localparam logic [1:0] ZONE_ABOVE  = 2'h2;

  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_PS_FORCE = 8'h01;
  localparam logic [7:0] CMD_AL_FORCE = 8'h02;
  localparam logic [7:0] CMD_BO_FORCE = 8'h03;
  localparam logic [7:0] CMD_PS_AUTO  = 8'h04;
  localparam logic [7:0] CMD_AL_AUTO  = 8'h05;
  localparam logic [7:0] CMD_BO_AUTO  = 8'h06;
  localparam logic [7:0] CMD_STOP     = 8'h07;

  typedef enum logic [0:0] {
    SQ_IDLE  = 1'b0,
    SQ_INTEG = 1'b1
  } pals_state_t;
endpackage

/* rtl/pals_rate_tmr.sv */
/*
  Autonomous measurement rate timer: counts unit ticks and pulses fire every
  rate units while run is high. Assumes unit_tick is a one-cycle enable on pclk.
*/
`timescale 1ns/1ps
module pals_rate_tmr #(
  parameter int W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         run,
  input  wire logic         unit_tick,
  input  wire logic [W-1:0] rate,
  output logic              fire
);
  logic [W-1:0] cnt_r, cnt_nxt;
  logic         fire_r, fire_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    fire_nxt = 1'b0;
    // rate zero means this sensor never self-starts
    if (!run || rate == '0) begin
      cnt_nxt = '0;
    end else if (unit_tick) begin
      if (cnt_r >= W'(rate - 1'b1)) begin
        cnt_nxt  = '0;
        fire_nxt = 1'b1;
      end else begin
        cnt_nxt = W'(cnt_r + 1'b1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= '0;
      fire_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      fire_r <= fire_nxt;
    end
  end

  assign fire = fire_r;
endmodule

/* rtl/pals_seq.sv */
/*
  Proximity / ambient light measurement sequencer with APB register slave.
  Runs up to three LED-lit proximity conversions and visible / infrared
  ambient conversions, stores results, flags overflow, raises irq.
  Assumes an analog front end on pclk that converts while adc_conv is high
  and holds adc_data / adc_ovf valid at the last cycle of integration.
*/
// Functional notes
// - each proximity event runs up to three conversions, only enabled ones
// - every proximity conversion has its own LED driver selection
// - default one LED per conversion; masks allow reversed order or all LEDs
// - per-channel proximity threshold, interrupt on crossing when enabled
// - optional interrupt when a full proximity set finishes, thresholds ignored
// - each LED current has its own setting, changeable any time
// - selectable low or high ADC signal range
// - proximity saturation flags overflow and stores 0x0FFF
// - data registers return to normal results once light is in range
// - overflow flags hold until the no-operation command clears them
// - commands still execute while overflow is flagged
// - infrared ambient has its own result channel, disabled via channel list
// - ambient results are 16 bits; high range avoids sunlight overflow
// - integration time 25.6 us default, up to 3.28 ms via gain steps
// - visible and infrared ambient each have their own integration setting
// - ambient saturation flags overflow and stores 0xFFFF
// - measurements start on host command or from autonomous timers
// - ambient and proximity autonomous rates are separate settings
// - ambient interrupt on every sample or only on window change
// - ambient window of lower and upper threshold, irq when either crossed
// - window watches exactly one ambient channel, visible or infrared
`timescale 1ns/1ps
module pals_seq #(
  parameter int unsigned INTEG_BASE = pals_pkg::INTEG_BASE_CYC,
  parameter int unsigned RATE_UNIT  = pals_pkg::RATE_UNIT_CYC
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [7:0]                paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic      [pals_pkg::NUM_PS-1:0] led_en,
  output logic      [3:0]                led_cur0,
  output logic      [3:0]                led_cur1,
  output logic      [3:0]                led_cur2,
  output logic                           adc_conv,
  output logic      [2:0]                adc_chan,
  output logic                           adc_range,
  input  wire logic [15:0]               adc_data,
  input  wire logic                      adc_ovf,
  output logic                           irq
);
  import pals_pkg::*;

  function automatic logic [2:0] first_ch(input logic [NUM_CH-1:0] m);
    first_ch = 3'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (m[i]) first_ch = 3'(i);
    end
  endfunction

  // ps channels share one ADC group, visible and infrared have their own
  function automatic logic [3:0] adc_fld(input logic [11:0] cfg, input logic [2:0] ch);
    if (ch < 3'(NUM_PS)) adc_fld = cfg[3:0];
    else if (ch == 3'(CH_VIS)) adc_fld = cfg[7:4];
    else adc_fld = cfg[11:8];
  endfunction

  // configuration registers
  logic [NUM_CH-1:0] channel_select_list_r, channel_select_list_nxt;
  logic [11:0]       ps_led_r, ps_led_nxt;
  logic [11:0]       led_cur_r, led_cur_nxt;
  logic [11:0]       adc_cfg_r, adc_cfg_nxt;
  logic [15:0]       ps_rate_r, ps_rate_nxt;
  logic [15:0]       als_rate_r, als_rate_nxt;
  logic [6:0]        int_cfg_r, int_cfg_nxt;
  logic [15:0]       ps_thr_r [NUM_PS];
  logic [15:0]       ps_thr_nxt [NUM_PS];
  logic [15:0]       win_lo_r, win_lo_nxt;
  logic [15:0]       win_hi_r, win_hi_nxt;
  logic              pready_r, pready_nxt;
  logic              pslverr_r, pslverr_nxt;
  logic [31:0]       prdata_r, prdata_nxt;
  // sequencer state
  pals_state_t       state_r, state_nxt;
  logic [2:0]        ch_r, ch_nxt;
  logic [NUM_CH-1:0] mask_r, mask_nxt;
  logic              has_ps_r, has_ps_nxt;
  logic [23:0]       cnt_r, cnt_nxt;
  logic              ps_pend_r, ps_pend_nxt;
  logic              als_pend_r, als_pend_nxt;
  logic              auto_ps_r, auto_ps_nxt;
  logic              auto_als_r, auto_als_nxt;
  logic [15:0]       data_r [NUM_CH];
  logic [15:0]       data_nxt [NUM_CH];
  logic [NUM_CH-1:0] ovf_r, ovf_nxt;
  logic [5:0]        int_st_r, int_st_nxt;
  logic [NUM_PS-1:0] above_r, above_nxt;
  logic [1:0]        zone_r, zone_nxt;
  logic [NUM_PS-1:0] led_en_r, led_en_nxt;
  logic              conv_r, conv_nxt;
  logic              range_r, range_nxt;
  logic              irq_r, irq_nxt;
  logic [15:0]       div_r, div_nxt;
  logic              tick_r, tick_nxt;

  logic        wr_go;
  logic        cmd_wr;
  logic        rd_hit;
  logic [31:0] rd_data;
  logic        ps_fire;
  logic        als_fire;

  assign wr_go  = psel && penable && pwrite && pready_r && !pslverr_r;
  assign cmd_wr = wr_go && paddr == OFF_CMD;

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = '0;
    unique case (paddr)
      OFF_CMD:     rd_data = '0;
      OFF_RESP:    rd_data = {23'h00_0000, state_r == SQ_INTEG, 3'h0, ovf_r};
      OFF_CHANNEL_SELECT_LIST:  rd_data = {27'h000_0000, channel_select_list_r};
      OFF_PS_LED:  rd_data = {20'h0_0000, ps_led_r};
      OFF_LED_CUR: rd_data = {20'h0_0000, led_cur_r};
      OFF_ADC_CFG: rd_data = {20'h0_0000, adc_cfg_r};
      OFF_RATE:    rd_data = {als_rate_r, ps_rate_r};
      OFF_INT_CFG: rd_data = {25'h000_0000, int_cfg_r};
      OFF_INT_ST:  rd_data = {26'h000_0000, int_st_r};
      OFF_WIN:     rd_data = {win_hi_r, win_lo_r};
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < NUM_PS; i++) begin
          if (paddr == 8'(OFF_PS_THR0 + 4 * i)) begin
            rd_hit  = 1'b1;
            rd_data = {16'h0000, ps_thr_r[i]};
          end
        end
        for (int i = 0; i < NUM_CH; i++) begin
          if (paddr == 8'(OFF_DATA0 + 4 * i)) begin
            rd_hit  = 1'b1;
            rd_data = {16'h0000, data_r[i]};
          end
        end
      end
    endcase
  end

  // bus slave and configuration: no wait states, writes land at completion
  always_comb begin
    pready_nxt   = 1'b0;
    pslverr_nxt  = pslverr_r;
    prdata_nxt   = prdata_r;
    channel_select_list_nxt   = channel_select_list_r;
    ps_led_nxt   = ps_led_r;
    led_cur_nxt  = led_cur_r;
    adc_cfg_nxt  = adc_cfg_r;
    ps_rate_nxt  = ps_rate_r;
    als_rate_nxt = als_rate_r;
    int_cfg_nxt  = int_cfg_r;
    ps_thr_nxt   = ps_thr_r;
    win_lo_nxt   = win_lo_r;
    win_hi_nxt   = win_hi_r;
    if (psel && !penable) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !rd_hit;
      prdata_nxt  = pwrite ? 32'h0000_0000 : rd_data;
    end
    if (wr_go) begin
      unique case (paddr)
        OFF_CHANNEL_SELECT_LIST:  channel_select_list_nxt = pwdata[NUM_CH-1:0];
        OFF_PS_LED:  ps_led_nxt = pwdata[11:0];
        OFF_LED_CUR: led_cur_nxt = pwdata[11:0];
        OFF_ADC_CFG: adc_cfg_nxt = pwdata[11:0];
        OFF_RATE: begin
          ps_rate_nxt  = pwdata[15:0];
          als_rate_nxt = pwdata[31:16];
        end
        OFF_INT_CFG: int_cfg_nxt = pwdata[6:0];
        OFF_WIN: begin
          win_lo_nxt = pwdata[15:0];
          win_hi_nxt = pwdata[31:16];
        end
        default: begin
          for (int i = 0; i < NUM_PS; i++) begin
            if (paddr == 8'(OFF_PS_THR0 + 4 * i)) ps_thr_nxt[i] = pwdata[15:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      prdata_r   <= 32'h0000_0000;
      channel_select_list_r   <= CHANNEL_SELECT_LIST_RST;
      ps_led_r   <= PS_LED_RST;
      led_cur_r  <= LED_CUR_RST;
      adc_cfg_r  <= ADC_CFG_RST;
      ps_rate_r  <= 16'h0000;
      als_rate_r <= 16'h0000;
      int_cfg_r  <= 7'h00;
      ps_thr_r   <= '{default: 16'h0000};
      win_lo_r   <= 16'h0000;
      win_hi_r   <= 16'hFFFF;
    end else begin
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
      prdata_r   <= prdata_nxt;
      channel_select_list_r   <= channel_select_list_nxt;
      ps_led_r   <= ps_led_nxt;
      led_cur_r  <= led_cur_nxt;
      adc_cfg_r  <= adc_cfg_nxt;
      ps_rate_r  <= ps_rate_nxt;
      als_rate_r <= als_rate_nxt;
      int_cfg_r  <= int_cfg_nxt;
      ps_thr_r   <= ps_thr_nxt;
      win_lo_r   <= win_lo_nxt;
      win_hi_r   <= win_hi_nxt;
    end
  end

  // rate unit divider, one pulse per RATE_UNIT cycles
  always_comb begin
    tick_nxt = 1'b0;
    div_nxt  = 16'(div_r + 1'b1);
    if (div_r == 16'(RATE_UNIT - 1)) begin
      div_nxt  = 16'h0000;
      tick_nxt = 1'b1;
    end
  end

  pals_rate_tmr #(.W(16)) u_ps_tmr (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (auto_ps_r),
    .unit_tick (tick_r),
    .rate      (ps_rate_r),
    .fire      (ps_fire)
  );

  pals_rate_tmr #(.W(16)) u_als_tmr (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (auto_als_r),
    .unit_tick (tick_r),
    .rate      (als_rate_r),
    .fire      (als_fire)
  );

  // measurement sequencer
  always_comb begin
    logic [NUM_CH-1:0] rem;
    logic              start;
    logic [15:0]       res;
    logic              above;
    logic [1:0]        zone;
    logic [3:0]        fld;
    rem          = mask_r;
    start        = 1'b0;
    res          = adc_data;
    above        = 1'b0;
    zone         = ZONE_INSIDE;
    fld          = 4'h0;
    state_nxt    = state_r;
    ch_nxt       = ch_r;
    mask_nxt     = mask_r;
    has_ps_nxt   = has_ps_r;
    cnt_nxt      = cnt_r;
    ps_pend_nxt  = ps_pend_r;
    als_pend_nxt = als_pend_r;
    auto_ps_nxt  = auto_ps_r;
    auto_als_nxt = auto_als_r;
    data_nxt     = data_r;
    ovf_nxt      = ovf_r;
    int_st_nxt   = int_st_r;
    above_nxt    = above_r;
    zone_nxt     = zone_r;
    // clears first so that a same-cycle hardware set wins
    if (cmd_wr && pwdata[7:0] == CMD_NOP) ovf_nxt = '0;
    if (wr_go && paddr == OFF_INT_ST) int_st_nxt = int_st_r & ~pwdata[5:0];
    unique case (state_r)
      SQ_IDLE: begin
        if (ps_pend_r || als_pend_r) begin
          rem          = channel_select_list_r & {{2{als_pend_r}}, {NUM_PS{ps_pend_r}}};
          has_ps_nxt   = ps_pend_r && (|channel_select_list_r[NUM_PS-1:0]);
          ps_pend_nxt  = 1'b0;
          als_pend_nxt = 1'b0;
          start        = |rem;
        end
      end
      SQ_INTEG: begin
        if (cnt_r > 24'h00_0001) begin
          cnt_nxt = 24'(cnt_r - 1'b1);
        end else begin
          if (ch_r < 3'(NUM_PS)) begin
            res   = adc_ovf ? PS_SAT : adc_data;
            above = res > ps_thr_r[ch_r[1:0]];
            if (int_cfg_r[IC_PS_THR + 32'(ch_r)] && above != above_r[ch_r[1:0]]) begin
              int_st_nxt[ST_PS_THR + 32'(ch_r)] = 1'b1;
            end
            above_nxt[ch_r[1:0]] = above;
          end else begin
            res = adc_ovf ? ALS_SAT : adc_data;
            if (int_cfg_r[IC_ALS_EVERY]) int_st_nxt[ST_ALS_SMP] = 1'b1;
            if (ch_r == (int_cfg_r[IC_WIN_IR] ? 3'(CH_IR) : 3'(CH_VIS))) begin
              zone = (res < win_lo_r) ? ZONE_BELOW :
                     (res > win_hi_r) ? ZONE_ABOVE : ZONE_INSIDE;
              if (int_cfg_r[IC_ALS_WIN] && zone != zone_r) begin
                int_st_nxt[ST_ALS_WIN] = 1'b1;
              end
              zone_nxt = zone;
            end
          end
          data_nxt[ch_r] = res;
          if (adc_ovf) ovf_nxt[ch_r] = 1'b1;
          rem   = mask_r & ~(5'h01 << ch_r);
          start = |rem;
          if (!start) begin
            state_nxt = SQ_IDLE;
            if (has_ps_r && int_cfg_r[IC_PS_SET]) int_st_nxt[ST_PS_SET] = 1'b1;
          end
        end
      end
    endcase
    if (start) begin
      state_nxt = SQ_INTEG;
      ch_nxt    = first_ch(rem);
      mask_nxt  = rem;
    end
    fld = adc_fld(adc_cfg_r, ch_nxt);
    if (start) cnt_nxt = 24'(INTEG_BASE) << fld[2:0];
    // commands are honoured regardless of the overflow flags
    if (cmd_wr) begin
      unique case (pwdata[7:0])
        CMD_PS_FORCE: ps_pend_nxt = 1'b1;
        CMD_AL_FORCE: als_pend_nxt = 1'b1;
        CMD_BO_FORCE: begin
          ps_pend_nxt  = 1'b1;
          als_pend_nxt = 1'b1;
        end
        CMD_PS_AUTO: auto_ps_nxt = 1'b1;
        CMD_AL_AUTO: auto_als_nxt = 1'b1;
        CMD_BO_AUTO: begin
          auto_ps_nxt  = 1'b1;
          auto_als_nxt = 1'b1;
        end
        CMD_STOP: begin
          auto_ps_nxt  = 1'b0;
          auto_als_nxt = 1'b0;
        end
        default: ;
      endcase
    end
    if (ps_fire) ps_pend_nxt = 1'b1;
    if (als_fire) als_pend_nxt = 1'b1;
    conv_nxt   = state_nxt == SQ_INTEG;
    range_nxt  = conv_nxt && fld[ADC_RANGE];
    led_en_nxt = '0;
    if (conv_nxt && ch_nxt < 3'(NUM_PS)) begin
      led_en_nxt = ps_led_r[{ch_nxt[1:0], 2'h0} +: NUM_PS];
    end
    irq_nxt = |int_st_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= SQ_IDLE;
      ch_r       <= 3'h0;
      mask_r     <= '0;
      has_ps_r   <= 1'b0;
      cnt_r      <= 24'h00_0000;
      ps_pend_r  <= 1'b0;
      als_pend_r <= 1'b0;
      auto_ps_r  <= 1'b0;
      auto_als_r <= 1'b0;
      data_r     <= '{default: 16'h0000};
      ovf_r      <= '0;
      int_st_r   <= 6'h00;
      above_r    <= '0;
      zone_r     <= ZONE_INSIDE;
      led_en_r   <= '0;
      conv_r     <= 1'b0;
      range_r    <= 1'b0;
      irq_r      <= 1'b0;
      div_r      <= 16'h0000;
      tick_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      ch_r       <= ch_nxt;
      mask_r     <= mask_nxt;
      has_ps_r   <= has_ps_nxt;
      cnt_r      <= cnt_nxt;
      ps_pend_r  <= ps_pend_nxt;
      als_pend_r <= als_pend_nxt;
      auto_ps_r  <= auto_ps_nxt;
      auto_als_r <= auto_als_nxt;
      data_r     <= data_nxt;
      ovf_r      <= ovf_nxt;
      int_st_r   <= int_st_nxt;
      above_r    <= above_nxt;
      zone_r     <= zone_nxt;
      led_en_r   <= led_en_nxt;
      conv_r     <= conv_nxt;
      range_r    <= range_nxt;
      irq_r      <= irq_nxt;
      div_r      <= div_nxt;
      tick_r     <= tick_nxt;
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign led_en    = led_en_r;
  assign led_cur0  = led_cur_r[3:0];
  assign led_cur1  = led_cur_r[7:4];
  assign led_cur2  = led_cur_r[11:8];
  assign adc_conv  = conv_r;
  assign adc_chan  = ch_r;
  assign adc_range = range_r;
  assign irq       = irq_r;
endmodule

/* test/pals_seq_properties.sv */
/*
  Checker for the measurement sequencer: APB answer timing, LED gating,
  integration length and irq cause / clear timing.
  Assumes it is bound to pals_seq and sees only its ports.
*/
`timescale 1ns/1ps
module pals_seq_chk
  import pals_pkg::*;
#(
  parameter int unsigned INTEG_BASE = 4
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic [7:0]          paddr,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [NUM_PS-1:0]   led_en,
  input wire logic                adc_conv,
  input wire logic [2:0]          adc_chan,
  input wire logic                irq
);
  int unsigned cnt_r;
  int unsigned cnt_nxt;

  // back-to-back channels may keep adc_conv high, so only a lower bound holds
  always_comb cnt_nxt = adc_conv ? cnt_r + 1 : 0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 0;
    else          cnt_r <= cnt_nxt;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_access_answer: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_ready_access: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("ready outside access");
  a_unmapped_err: assert property (pready && paddr > 8'h44 |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (pready && paddr <= 8'h44 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error on mapped access");
  a_idle_dark: assert property (!adc_conv |-> led_en == '0)
    else $error("led on outside conversion");
  a_ambient_dark: assert property (adc_conv && adc_chan >= 3'd3 |-> led_en == '0)
    else $error("led on in ambient conversion");
  a_chan_legal: assert property (adc_conv |-> adc_chan <= 3'd4)
    else $error("illegal channel");
  a_integ_min: assert property ($fell(adc_conv) |-> cnt_r >= INTEG_BASE)
    else $error("integration too short");
  a_irq_cause: assert property ($rose(irq) |-> $past(adc_conv, 2))
    else $error("irq without conversion end");
  a_irq_clear: assert property ($fell(irq) |->
      $past(psel && penable && pwrite && paddr == OFF_INT_ST, 1))
    else $error("irq fell without status clear");
endmodule

bind pals_seq pals_seq_chk #(.INTEG_BASE(INTEG_BASE)) u_pals_seq_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .led_en(led_en),
  .adc_conv(adc_conv), .adc_chan(adc_chan), .irq(irq));

/* test/pals_fe_model.sv */
/*
  Analog front end model: returns the bench's infrared level on the infrared
  channel and its visible level on every other channel while converting.
  Assumes sampling at the last integration cycle.
*/
`timescale 1ns/1ps
module pals_fe_model
  import pals_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        adc_conv,
  input  wire logic [2:0]  adc_chan,
  input  wire logic [15:0] vis_v,
  input  wire logic [15:0] ir_v,
  input  wire logic        ovf_in,
  output logic      [15:0] adc_data = 16'h5A5A,
  output logic             adc_ovf = 1'b0
);
  // outside a conversion the lines churn so stale data cannot pass
  always @(posedge pclk) begin
    if (adc_conv) begin
      adc_data <= (adc_chan == 3'(CH_IR)) ? ir_v : vis_v;
      adc_ovf  <= ovf_in;
    end else begin
      adc_data <= ~adc_data;
      adc_ovf  <= ~adc_ovf;
    end
  end
endmodule

/* test/tb_pals_seq.sv */
/*
  Self-checking bench for pals_seq: APB master tasks and one task per
  scenario. Assumes the front end model and the bound checker.
*/
`timescale 1ns/1ps
module tb_pals_seq;
  import pals_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ovf_in = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic        pready, pslverr, serr, adc_conv, adc_range, adc_ovf, irq;
  logic [2:0]  led_en, adc_chan, seen [5];
  logic [3:0]  led_cur0, led_cur1, led_cur2;
  logic [15:0] adc_data, vis_v = 0, ir_v = 0;
  int          cyc [5], rng [5];
  int          err_count = 0, samples_checked = 0;

  always #20 pclk = ~pclk;
  pals_seq #(.INTEG_BASE(4), .RATE_UNIT(8)) u_pals_seq (.*);
  pals_fe_model u_pals_fe_model (.*);

  always @(posedge pclk) if (adc_conv) begin
    cyc[adc_chan] <= cyc[adc_chan] + 1;
    rng[adc_chan] <= adc_range;
    seen[adc_chan] <= led_en;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pre-edge values: the answer as sampled at this rising edge
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    chk(q, e);
  endtask
  // busy may lag the command by a cycle, hence the short fixed wait
  task automatic run(input logic [7:0] c);
    wr(OFF_CMD, {24'h00_0000, c});
    repeat (3) @(posedge pclk);
    for (int k = 0; k < 100; k++) begin
      apb(OFF_RESP, 1'b0, 32'h0000_0000);
      if (q[RESP_BUSY] === 1'b0) break;
    end
    repeat (2) @(posedge pclk);
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic t_regs;
    rd(OFF_CHANNEL_SELECT_LIST, 32'h0000_0009);
    rd(OFF_PS_LED, 32'h0000_0421);
    rd(OFF_ADC_CFG, 32'h0000_0000);
    rd(OFF_WIN, 32'hFFFF_0000);
    rd(8'h48, 32'h0000_0000);
    chk({31'h0000_0000, serr}, 32'h0000_0001);
    $display("test regs done");
  endtask
  task automatic t_ps;
    wr(OFF_CHANNEL_SELECT_LIST, 32'h0000_0007);
    wr(OFF_PS_LED, 32'h0000_0124);
    wr(OFF_LED_CUR, 32'h0000_0321);
    chk({20'h0_0000, led_cur2, led_cur1, led_cur0}, 32'h0000_0321);
    wr(OFF_INT_CFG, 32'h0000_0001);
    vis_v = 16'h0055;
    run(CMD_PS_FORCE);
    chk({23'h00_0000, seen[0], seen[1], seen[2]}, {23'h00_0000, 3'd4, 3'd2, 3'd1});
    for (int i = 0; i < 3; i++) rd(OFF_DATA0 + 8'(4 * i), 32'h0000_0055);
    rd(OFF_INT_ST, 32'h0000_0001);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wr(OFF_INT_ST, 32'h0000_003F);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wr(OFF_CHANNEL_SELECT_LIST, 32'h0000_0001);
    wr(OFF_PS_LED, 32'h0000_0777);
    run(CMD_PS_FORCE);
    chk({29'h0000_0000, seen[0]}, 32'h0000_0007);
    wr(OFF_INT_ST, 32'h0000_003F);
    $display("test ps done");
  endtask
  task automatic t_ovf;
    wr(OFF_INT_CFG, 32'h0000_0000);
    wr(OFF_CHANNEL_SELECT_LIST, 32'h0000_0009);
    ovf_in = 1'b1;
    run(CMD_BO_FORCE);
    rd(OFF_DATA0, {16'h0000, PS_SAT});
    rd(OFF_DATA0 + 8'h0C, {16'h0000, ALS_SAT});
    rd(OFF_RESP, 32'h0000_0009);
    ovf_in = 1'b0;
    vis_v = 16'hFEDC;
    run(CMD_BO_FORCE);
    rd(OFF_DATA0, 32'h0000_FEDC);
    rd(OFF_DATA0 + 8'h0C, 32'h0000_FEDC);
    rd(OFF_RESP, 32'h0000_0009);
    wr(OFF_CMD, {24'h00_0000, CMD_NOP});
    rd(OFF_RESP, 32'h0000_0000);
    $display("test overflow done");
  endtask
  task automatic t_thr;
    wr(OFF_CHANNEL_SELECT_LIST, 32'h0000_0001);
    wr(OFF_PS_THR0, 32'h0000_0080);
    wr(OFF_INT_CFG, 32'h0000_0002);
    vis_v = 16'h0010;
    run(CMD_PS_FORCE);
    rd(OFF_INT_ST, 32'h0000_0002);
    wr(OFF_INT_ST, 32'h0000_0002);
    run(CMD_PS_FORCE);
    rd(OFF_INT_ST, 32'h0000_0000);
    vis_v = 16'h0090;
    run(CMD_PS_FORCE);
    rd(OFF_INT_ST, 32'h0000_0002);
    wr(OFF_INT_ST, 32'h0000_003F);
    $display("test threshold done");
  endtask
  task automatic t_als;
    wr(OFF_CHANNEL_SELECT_LIST, 32'h0000_0018);
    wr(OFF_ADC_CFG, 32'h0000_0810);
    wr(OFF_WIN, 32'h0200_0100);
    wr(OFF_INT_CFG, 32'h0000_0020);
    vis_v = 16'h0150;
    ir_v = 16'h0900;
    cyc = '{default: 0};
    run(CMD_AL_FORCE);
    chk(32'(cyc[3]), 32'h0000_0008);
    chk(32'(cyc[4]), 32'h0000_0004);
    chk(32'(rng[3] * 2 + rng[4]), 32'h0000_0001);
    rd(OFF_INT_ST, 32'h0000_0000);
    vis_v = 16'h0300;
    run(CMD_AL_FORCE);
    rd(OFF_INT_ST, 32'h0000_0020);
    wr(OFF_INT_ST, 32'h0000_003F);
    ir_v = 16'h0010;
    run(CMD_AL_FORCE);
    rd(OFF_INT_ST, 32'h0000_0000);
    wr(OFF_INT_CFG, 32'h0000_0010);
    run(CMD_AL_FORCE);
    rd(OFF_INT_ST, 32'h0000_0010);
    wr(OFF_INT_ST, 32'h0000_003F);
    $display("test ambient done");
  endtask
  task automatic t_auto;
    int k;
    wr(OFF_CHANNEL_SELECT_LIST, 32'h0000_0008);
    wr(OFF_RATE, 32'h0002_0000);
    wr(OFF_CMD, {24'h00_0000, CMD_AL_AUTO});
    for (k = 0; k < 400 && irq !== 1'b1; k++) @(posedge pclk);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wr(OFF_CMD, {24'h00_0000, CMD_STOP});
    repeat (40) @(posedge pclk);
    wr(OFF_INT_ST, 32'h0000_003F);
    repeat (60) @(posedge pclk);
    rd(OFF_INT_ST, 32'h0000_0000);
    $display("test autonomous done");
  endtask

  initial begin
    repeat (50000) @(posedge pclk);
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_ps();
    t_ovf();
    t_thr();
    t_als();
    t_auto();
    print_verdict();
  end
endmodule
